/* File: common/stpm_map.svh */
// offsets, field positions, reset values and function codes for the pad mux
// assumes: included by its bare name from the package and the design files
`ifndef STPM_MAP_SVH
`define STPM_MAP_SVH

// ----------------------------------------
// pad slots
// ----------------------------------------
`define STPM_PAD_COUNT 5
`define STPM_PAD_B2    0
`define STPM_PAD_B3    1
`define STPM_PAD_A0    2
`define STPM_PAD_A4    3
`define STPM_PAD_A5    4

// ----------------------------------------
// function codes
// ----------------------------------------
`define STPM_FUNC_W     2
`define STPM_FUNC_GPIO  2'h0
`define STPM_FUNC_SPI   2'h1
`define STPM_FUNC_TIMER 2'h2
`define STPM_FUNC_PWM   2'h3

// legal function set per pad, one bit per function code
`define STPM_LEGAL_B2   4'h7
`define STPM_LEGAL_B3   4'h7
`define STPM_LEGAL_A0   4'h9
`define STPM_LEGAL_A4   4'h5
`define STPM_LEGAL_A5   4'h5

// ----------------------------------------
// reset values
// ----------------------------------------
`define STPM_RST_FUNC   2'h0
`define STPM_RST_PULL   1'h1
`define STPM_RST_OE_N   1'h1
`define STPM_RST_LEVEL  1'h0

`endif

/* File: common/stpm_pkg.sv */
// types shared by the pad mux and its pad cells
// assumes: stpm_map.svh is on the include path
package stpm_pkg;
`include "stpm_map.svh"

    // ----------------------------------------
    // pad function selection
    // ----------------------------------------
    typedef enum logic [`STPM_FUNC_W-1:0]
    {
        STPM_FN_GPIO  = `STPM_FUNC_GPIO,
        STPM_FN_SPI   = `STPM_FUNC_SPI,
        STPM_FN_TIMER = `STPM_FUNC_TIMER,
        STPM_FN_PWM   = `STPM_FUNC_PWM
    } stpm_func_t;

endpackage

/* File: src/stpm_pad_cell.sv */
// one pad: registered output level, output enable and input sample
// assumes: single core clock, asynchronous active-low reset, pad input synchronous
`include "stpm_map.svh"

module stpm_pad_cell
(
    input  wire logic i_core_clk,
    input  wire logic i_resetn,
    input  wire logic i_next_drive,
    input  wire logic i_next_level,
    input  wire logic i_pad_in,
    output logic      o_pad_out,
    output logic      o_pad_oe_n,
    output logic      o_pull_up_en,
    output logic      o_pad_seen
);
    import stpm_pkg::*;

    // ----------------------------------------
    // pad flops
    // ----------------------------------------
    // reset leaves the pad an input with pull-up on, nothing driven
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_pad_oe_n   <= `STPM_RST_OE_N;
            o_pad_out    <= `STPM_RST_LEVEL;
            o_pull_up_en <= `STPM_RST_PULL;
            o_pad_seen   <= `STPM_RST_LEVEL;
        end
        else
        begin
            o_pad_oe_n   <= !i_next_drive;
            o_pad_out    <= i_next_level;
            o_pull_up_en <= !i_next_drive; // pull-up only while listening
            o_pad_seen   <= i_pad_in;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_reset_release_quiet;
        @(posedge i_core_clk) disable iff (!i_resetn)
        $rose(i_resetn) |-> (o_pad_oe_n && o_pull_up_en);
    endproperty
    a_reset_release_quiet: assert property (p_reset_release_quiet)
        else $error("pad driven or pull-up off at reset release");

endmodule // stpm_pad_cell

/* File: src/stpm_pin_mux.sv */
// pin multiplexer for two port b pads and three port a pads
// assumes: function choices come from the system integration module with a load strobe,
// the spi, timer and pwm engines run on the same core clock, pads are synchronous
`include "stpm_map.svh"

module stpm_pin_mux
#(
    parameter int PAD_COUNT = `STPM_PAD_COUNT
)
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_resetn,
    // system integration configuration
    input  wire logic                  i_sysint_load,
    input  wire stpm_pkg::stpm_func_t  i_sysint_func_b2,
    input  wire stpm_pkg::stpm_func_t  i_sysint_func_b3,
    input  wire stpm_pkg::stpm_func_t  i_sysint_func_a0,
    input  wire stpm_pkg::stpm_func_t  i_sysint_func_a4,
    input  wire stpm_pkg::stpm_func_t  i_sysint_func_a5,
    output stpm_pkg::stpm_func_t       o_func_b2,
    output stpm_pkg::stpm_func_t       o_func_b3,
    output stpm_pkg::stpm_func_t       o_func_a0,
    output stpm_pkg::stpm_func_t       o_func_a4,
    output stpm_pkg::stpm_func_t       o_func_a5,
    // general-purpose port side, bit order b2 b3 a0 a4 a5
    input  wire logic [PAD_COUNT-1:0]  i_gpio_dir,
    input  wire logic [PAD_COUNT-1:0]  i_gpio_out,
    output logic [PAD_COUNT-1:0]       o_gpio_in,
    // spi engine side
    input  wire logic                  i_spi_master,
    input  wire logic                  i_spi_select_n,
    input  wire logic                  i_spi_miso_data,
    input  wire logic                  i_spi_mosi_data,
    output logic                       o_spi_miso_in,
    output logic                       o_spi_mosi_in,
    // timer engine side
    input  wire logic                  i_timer_channel_two_out,
    input  wire logic                  i_timer_channel_two_drive,
    output logic                       o_timer_channel_two_in,
    input  wire logic                  i_timer_channel_three_out,
    input  wire logic                  i_timer_channel_three_drive,
    output logic                       o_timer_channel_three_in,
    // pwm engine side
    input  wire logic                  i_pulse_output_zero,
    // pads
    input  wire logic                  i_port_b_pad_two_in,
    output logic                       o_port_b_pad_two_out,
    output logic                       o_port_b_pad_two_oe_n,
    output logic                       o_port_b_pad_two_pull_up,
    input  wire logic                  i_port_b_pad_three_in,
    output logic                       o_port_b_pad_three_out,
    output logic                       o_port_b_pad_three_oe_n,
    output logic                       o_port_b_pad_three_pull_up,
    input  wire logic                  i_port_a_pad_zero_in,
    output logic                       o_port_a_pad_zero_out,
    output logic                       o_port_a_pad_zero_oe_n,
    output logic                       o_port_a_pad_zero_pull_up,
    input  wire logic                  i_port_a_pad_four_in,
    output logic                       o_port_a_pad_four_out,
    output logic                       o_port_a_pad_four_oe_n,
    output logic                       o_port_a_pad_four_pull_up,
    input  wire logic                  i_port_a_pad_five_in,
    output logic                       o_port_a_pad_five_out,
    output logic                       o_port_a_pad_five_oe_n,
    output logic                       o_port_a_pad_five_pull_up
);
    import stpm_pkg::*;

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    // the pad map is fixed by the package; other counts cannot be served
    if (PAD_COUNT != `STPM_PAD_COUNT)
    begin : g_bad_count
        $error("stpm_pin_mux: PAD_COUNT must equal the fixed pad map");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    stpm_func_t                 func_q   [PAD_COUNT];
    stpm_func_t                 req_func [PAD_COUNT];
    logic [3:0]                 legal    [PAD_COUNT];
    logic [PAD_COUNT-1:0]       next_drive;
    logic [PAD_COUNT-1:0]       next_level;
    logic [PAD_COUNT-1:0]       pad_in;
    logic [PAD_COUNT-1:0]       pad_out;
    logic [PAD_COUNT-1:0]       pad_oe_n;
    logic [PAD_COUNT-1:0]       pad_pull;
    logic [PAD_COUNT-1:0]       pad_seen;
    logic [PAD_COUNT-1:0]       is_gpio;
    logic                       b2_spi;
    logic                       b2_timer;
    logic                       b3_spi;
    logic                       b3_timer;
    logic                       a0_pwm;
    logic                       a4_timer;
    logic                       a5_timer;
    logic                       slave_selected;

    // ----------------------------------------
    // configuration requests and legal sets
    // ----------------------------------------
    assign req_func[`STPM_PAD_B2] = i_sysint_func_b2;
    assign req_func[`STPM_PAD_B3] = i_sysint_func_b3;
    assign req_func[`STPM_PAD_A0] = i_sysint_func_a0;
    assign req_func[`STPM_PAD_A4] = i_sysint_func_a4;
    assign req_func[`STPM_PAD_A5] = i_sysint_func_a5;
    assign legal[`STPM_PAD_B2]    = `STPM_LEGAL_B2;
    assign legal[`STPM_PAD_B3]    = `STPM_LEGAL_B3;
    assign legal[`STPM_PAD_A0]    = `STPM_LEGAL_A0;
    assign legal[`STPM_PAD_A4]    = `STPM_LEGAL_A4;
    assign legal[`STPM_PAD_A5]    = `STPM_LEGAL_A5;

    // ----------------------------------------
    // per-pad function register and pad cell
    // ----------------------------------------
    // a code the pad cannot carry falls back to general purpose, so a bad
    // write can never leave a pad driven by an engine it is not wired to
    for (genvar p = 0; p < PAD_COUNT; p++)
    begin : g_pad
        stpm_func_t next_func;

        assign next_func  = !i_sysint_load ? func_q[p]
                          : legal[p][req_func[p]] ? req_func[p]
                          : STPM_FN_GPIO;
        assign is_gpio[p] = (func_q[p] == STPM_FN_GPIO);

        always_ff @(posedge i_core_clk or negedge i_resetn)
        begin
            if (!i_resetn)
                func_q[p] <= stpm_func_t'(`STPM_RST_FUNC);
            else
                func_q[p] <= next_func;
        end

        stpm_pad_cell u_cell
        (
            .i_core_clk   (i_core_clk),
            .i_resetn     (i_resetn),
            .i_next_drive (next_drive[p]),
            .i_next_level (next_level[p]),
            .i_pad_in     (pad_in[p]),
            .o_pad_out    (pad_out[p]),
            .o_pad_oe_n   (pad_oe_n[p]),
            .o_pull_up_en (pad_pull[p]),
            .o_pad_seen   (pad_seen[p])
        );
    end

    // ----------------------------------------
    // decoded selections
    // ----------------------------------------
    assign b2_spi         = (func_q[`STPM_PAD_B2] == STPM_FN_SPI);
    assign b2_timer       = (func_q[`STPM_PAD_B2] == STPM_FN_TIMER);
    assign b3_spi         = (func_q[`STPM_PAD_B3] == STPM_FN_SPI);
    assign b3_timer       = (func_q[`STPM_PAD_B3] == STPM_FN_TIMER);
    assign a0_pwm         = (func_q[`STPM_PAD_A0] == STPM_FN_PWM);
    assign a4_timer       = (func_q[`STPM_PAD_A4] == STPM_FN_TIMER);
    assign a5_timer       = (func_q[`STPM_PAD_A5] == STPM_FN_TIMER);
    assign slave_selected = !i_spi_master && !i_spi_select_n;

    // ----------------------------------------
    // drive enables
    // ----------------------------------------
    // data and enable both take one flop, so the engine's half-cycle lead
    // over the sampling edge is kept intact at the pad
    assign next_drive[`STPM_PAD_B2] = is_gpio[`STPM_PAD_B2] ? i_gpio_dir[`STPM_PAD_B2]
                                    : b2_spi   ? slave_selected
                                    : b2_timer && i_timer_channel_two_drive;
    assign next_drive[`STPM_PAD_B3] = is_gpio[`STPM_PAD_B3] ? i_gpio_dir[`STPM_PAD_B3]
                                    : b3_spi   ? i_spi_master
                                    : b3_timer && i_timer_channel_three_drive;
    assign next_drive[`STPM_PAD_A0] = is_gpio[`STPM_PAD_A0] ? i_gpio_dir[`STPM_PAD_A0]
                                    : a0_pwm;
    assign next_drive[`STPM_PAD_A4] = is_gpio[`STPM_PAD_A4] ? i_gpio_dir[`STPM_PAD_A4]
                                    : a4_timer && i_timer_channel_two_drive;
    assign next_drive[`STPM_PAD_A5] = is_gpio[`STPM_PAD_A5] ? i_gpio_dir[`STPM_PAD_A5]
                                    : a5_timer && i_timer_channel_three_drive;

    // ----------------------------------------
    // output levels
    // ----------------------------------------
    assign next_level[`STPM_PAD_B2] = is_gpio[`STPM_PAD_B2] ? i_gpio_out[`STPM_PAD_B2]
                                    : b2_spi ? i_spi_miso_data
                                    : i_timer_channel_two_out;
    assign next_level[`STPM_PAD_B3] = is_gpio[`STPM_PAD_B3] ? i_gpio_out[`STPM_PAD_B3]
                                    : b3_spi ? i_spi_mosi_data
                                    : i_timer_channel_three_out;
    assign next_level[`STPM_PAD_A0] = is_gpio[`STPM_PAD_A0] ? i_gpio_out[`STPM_PAD_A0]
                                    : i_pulse_output_zero;
    assign next_level[`STPM_PAD_A4] = is_gpio[`STPM_PAD_A4] ? i_gpio_out[`STPM_PAD_A4]
                                    : i_timer_channel_two_out;
    assign next_level[`STPM_PAD_A5] = is_gpio[`STPM_PAD_A5] ? i_gpio_out[`STPM_PAD_A5]
                                    : i_timer_channel_three_out;

    // ----------------------------------------
    // inputs back to the engines
    // ----------------------------------------
    // pad b wins when a timer channel is routed to both pads at once
    assign o_gpio_in                = pad_seen;
    assign o_spi_miso_in            = b2_spi && i_spi_master && pad_seen[`STPM_PAD_B2];
    assign o_spi_mosi_in            = b3_spi && !i_spi_master && pad_seen[`STPM_PAD_B3];
    assign o_timer_channel_two_in   = b2_timer ? pad_seen[`STPM_PAD_B2]
                                    : a4_timer && pad_seen[`STPM_PAD_A4];
    assign o_timer_channel_three_in = b3_timer ? pad_seen[`STPM_PAD_B3]
                                    : a5_timer && pad_seen[`STPM_PAD_A5];

    // ----------------------------------------
    // pad and status ports
    // ----------------------------------------
    assign pad_in[`STPM_PAD_B2]       = i_port_b_pad_two_in;
    assign pad_in[`STPM_PAD_B3]       = i_port_b_pad_three_in;
    assign pad_in[`STPM_PAD_A0]       = i_port_a_pad_zero_in;
    assign pad_in[`STPM_PAD_A4]       = i_port_a_pad_four_in;
    assign pad_in[`STPM_PAD_A5]       = i_port_a_pad_five_in;
    assign o_port_b_pad_two_out       = pad_out[`STPM_PAD_B2];
    assign o_port_b_pad_two_oe_n      = pad_oe_n[`STPM_PAD_B2];
    assign o_port_b_pad_two_pull_up   = pad_pull[`STPM_PAD_B2];
    assign o_port_b_pad_three_out     = pad_out[`STPM_PAD_B3];
    assign o_port_b_pad_three_oe_n    = pad_oe_n[`STPM_PAD_B3];
    assign o_port_b_pad_three_pull_up = pad_pull[`STPM_PAD_B3];
    assign o_port_a_pad_zero_out      = pad_out[`STPM_PAD_A0];
    assign o_port_a_pad_zero_oe_n     = pad_oe_n[`STPM_PAD_A0];
    assign o_port_a_pad_zero_pull_up  = pad_pull[`STPM_PAD_A0];
    assign o_port_a_pad_four_out      = pad_out[`STPM_PAD_A4];
    assign o_port_a_pad_four_oe_n     = pad_oe_n[`STPM_PAD_A4];
    assign o_port_a_pad_four_pull_up  = pad_pull[`STPM_PAD_A4];
    assign o_port_a_pad_five_out      = pad_out[`STPM_PAD_A5];
    assign o_port_a_pad_five_oe_n     = pad_oe_n[`STPM_PAD_A5];
    assign o_port_a_pad_five_pull_up  = pad_pull[`STPM_PAD_A5];
    assign o_func_b2                  = func_q[`STPM_PAD_B2];
    assign o_func_b3                  = func_q[`STPM_PAD_B3];
    assign o_func_a0                  = func_q[`STPM_PAD_A0];
    assign o_func_a4                  = func_q[`STPM_PAD_A4];
    assign o_func_a5                  = func_q[`STPM_PAD_A5];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_load_spi_b2;
        i_sysint_load && (i_sysint_func_b2 == STPM_FN_SPI);
    endsequence

    sequence s_b2_slave_live;
        b2_spi && !i_spi_master && !i_spi_select_n;
    endsequence

    property p_gpio_dir;
        (is_gpio[`STPM_PAD_B3] && i_gpio_dir[`STPM_PAD_B3])
            |=> !o_port_b_pad_three_oe_n && (o_port_b_pad_three_out == $past(i_gpio_out[1]));
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("gpio output pad not driving its data");

    property p_defaults;
        $rose(i_resetn) |-> (o_func_b2 == STPM_FN_GPIO) && (o_func_b3 == STPM_FN_GPIO)
                            && (o_func_a0 == STPM_FN_GPIO);
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("pad not in general-purpose function after reset");

    property p_sysint_select;
        s_load_spi_b2 |=> b2_spi ##1 (b2_spi || $past(i_sysint_load));
    endproperty
    a_sysint_select: assert property (p_sysint_select)
        else $error("configured function not taken or not held");

    property p_miso_master_in;
        (b2_spi && i_spi_master) |=> o_port_b_pad_two_oe_n && o_port_b_pad_two_pull_up;
    endproperty
    a_miso_master_in: assert property (p_miso_master_in)
        else $error("miso driven while master");

    property p_miso_deselect;
        (b2_spi && !i_spi_master && i_spi_select_n) |=> o_port_b_pad_two_oe_n;
    endproperty
    a_miso_deselect: assert property (p_miso_deselect)
        else $error("miso driven while slave deselected");

    property p_miso_data;
        s_b2_slave_live |=> !o_port_b_pad_two_oe_n
                            && (o_port_b_pad_two_out == $past(i_spi_miso_data));
    endproperty
    a_miso_data: assert property (p_miso_data)
        else $error("miso level or enable lags the engine");

    property p_mosi;
        (b3_spi && i_spi_master) |=> !o_port_b_pad_three_oe_n
                                     && (o_port_b_pad_three_out == $past(i_spi_mosi_data));
    endproperty
    a_mosi: assert property (p_mosi)
        else $error("mosi not driven by master");

    property p_timer_two_a4;
        (a4_timer && i_timer_channel_two_drive) |=> !o_port_a_pad_four_oe_n
            && (o_port_a_pad_four_out == $past(i_timer_channel_two_out));
    endproperty
    a_timer_two_a4: assert property (p_timer_two_a4)
        else $error("timer channel two missing on pad a four");

    property p_pwm;
        a0_pwm |=> !o_port_a_pad_zero_oe_n
                   && (o_port_a_pad_zero_out == $past(i_pulse_output_zero));
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("pulse output zero not driven");

    property p_timer_three_a5;
        (a5_timer && !b3_timer) |-> (o_timer_channel_three_in == pad_seen[`STPM_PAD_A5]);
    endproperty
    a_timer_three_a5: assert property (p_timer_three_a5)
        else $error("timer channel three input not from pad a five");

endmodule // stpm_pin_mux

/* File: testbench/stpm_pad_peer.sv */
// far side of the five pads: spi peer, timer load and pwm load
// assumes: pad vectors in order b2 b3 a0 a4 a5, pull-up on whenever released
module stpm_pad_peer
(
    input  wire logic [4:0] i_drive,
    input  wire logic [4:0] i_level,
    input  wire logic [4:0] i_pad_out,
    input  wire logic [4:0] i_pad_oe_n,
    input  wire logic [4:0] i_pull_up,
    output logic      [4:0] o_pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // peer drives only a released pad, so no contention; data lead belongs to engines
    assign o_pad = (~i_pad_oe_n & i_pad_out) | (i_pad_oe_n & i_drive & i_level)
                 | (i_pad_oe_n & ~i_drive & i_pull_up);
endmodule // stpm_pad_peer

/* File: testbench/stpm_pin_mux_test.sv */
// self-checking bench for the pad mux: random traffic, reference model, mid-run reset
// assumes: one 100 MHz core clock; pads resolved by stpm_pad_peer
`include "stpm_map.svh"
module stpm_pin_mux_test import stpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [4:0] oe_n, out, gin; logic [9:0] fn; logic [3:0] der;} stpm_note_t;
    logic i_core_clk = 0, i_resetn = 0, load = 0, master = 0, sel_n = 1, miso_d = 0, mosi_d = 0;
    logic t2o = 0, t2d = 0, t3o = 0, t3d = 0, pwm = 0, mi, mo, t2i, t3i;
    logic [4:0] dir = 0, gout = 0, pdrv = 0, plv = 0, pad, oe_n, out, pu, gin, poe_n, pout;
    logic [3:0] lg [5] = '{`STPM_LEGAL_B2, `STPM_LEGAL_B3, `STPM_LEGAL_A0, `STPM_LEGAL_A4,
                           `STPM_LEGAL_A5};
    stpm_func_t fc [5] = '{default: STPM_FN_GPIO};
    stpm_func_t of [5];
    stpm_func_t mf [5];
    stpm_note_t q [$];
    int mismatches = 0, tests_run = 0, seed;

    always #5 i_core_clk = ~i_core_clk;

    stpm_pin_mux dut_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_sysint_load(load),
        .i_sysint_func_b2(fc[0]), .i_sysint_func_b3(fc[1]), .i_sysint_func_a0(fc[2]),
        .i_sysint_func_a4(fc[3]), .i_sysint_func_a5(fc[4]), .o_func_b2(of[0]), .o_func_b3(of[1]),
        .o_func_a0(of[2]), .o_func_a4(of[3]), .o_func_a5(of[4]), .i_gpio_dir(dir),
        .i_gpio_out(gout), .o_gpio_in(gin), .i_spi_master(master), .i_spi_select_n(sel_n),
        .i_spi_miso_data(miso_d), .i_spi_mosi_data(mosi_d), .o_spi_miso_in(mi),
        .o_spi_mosi_in(mo), .i_timer_channel_two_out(t2o), .i_timer_channel_two_drive(t2d),
        .o_timer_channel_two_in(t2i), .i_timer_channel_three_out(t3o),
        .i_timer_channel_three_drive(t3d), .o_timer_channel_three_in(t3i),
        .i_pulse_output_zero(pwm), .i_port_b_pad_two_in(pad[0]), .o_port_b_pad_two_out(out[0]),
        .o_port_b_pad_two_oe_n(oe_n[0]), .o_port_b_pad_two_pull_up(pu[0]),
        .i_port_b_pad_three_in(pad[1]), .o_port_b_pad_three_out(out[1]),
        .o_port_b_pad_three_oe_n(oe_n[1]), .o_port_b_pad_three_pull_up(pu[1]),
        .i_port_a_pad_zero_in(pad[2]), .o_port_a_pad_zero_out(out[2]),
        .o_port_a_pad_zero_oe_n(oe_n[2]), .o_port_a_pad_zero_pull_up(pu[2]),
        .i_port_a_pad_four_in(pad[3]), .o_port_a_pad_four_out(out[3]),
        .o_port_a_pad_four_oe_n(oe_n[3]), .o_port_a_pad_four_pull_up(pu[3]),
        .i_port_a_pad_five_in(pad[4]), .o_port_a_pad_five_out(out[4]),
        .o_port_a_pad_five_oe_n(oe_n[4]), .o_port_a_pad_five_pull_up(pu[4]));

    stpm_pad_peer peer_u (.i_drive(pdrv), .i_level(plv), .i_pad_out(out), .i_pad_oe_n(oe_n),
        .i_pull_up(pu), .o_pad(pad));

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // reset: model back to gpio with every pad released
    task automatic enter_reset();
        i_resetn = 0;
        #1;
        check("reset pads", {oe_n, pu}, 10'h3ff);
        check("reset levels", {out, gin}, 10'h000);
        check("reset func", {of[0], of[1], of[2], of[3], of[4]}, 10'h000);
        mf = '{default: STPM_FN_GPIO};
        poe_n = 5'h1f;
        pout = 5'h00;
        q.delete();
    endtask

    // drive one cycle and note what the next edge must show
    task automatic step(bit ld);
        stpm_note_t n;
        logic [4:0] drv, lv, lvl;
        int r;
        {dir, gout, pdrv, plv} = 20'($random(seed));
        {miso_d, mosi_d, sel_n, t2o, t2d, t3o, t3d, pwm} = 8'($random(seed));
        r = $random(seed);
        load = ld;
        if (ld)
        begin
            master = r[10];
            for (int p = 0; p < 5; p++)
                fc[p] = stpm_func_t'(r[2*p+:2]);
        end
        for (int p = 0; p < 5; p++)
        begin
            case (mf[p])
                STPM_FN_SPI: {drv[p], lv[p]} = p == 0 ? {!master && !sel_n, miso_d} : {master, mosi_d};
                STPM_FN_TIMER: {drv[p], lv[p]} = (p == 0 || p == 3) ? {t2d, t2o} : {t3d, t3o};
                STPM_FN_PWM: {drv[p], lv[p]} = {1'b1, pwm};
                default: {drv[p], lv[p]} = {dir[p], gout[p]};
            endcase
            lvl[p] = !poe_n[p] ? pout[p] : pdrv[p] ? plv[p] : 1'b1;
        end
        if (ld)
            for (int p = 0; p < 5; p++)
                mf[p] = lg[p][fc[p]] ? fc[p] : STPM_FN_GPIO; // illegal codes load as gpio
        // engine inputs decode the function the coming edge loads, against the pad it saw
        n.der = {mf[0] == STPM_FN_SPI && master && lvl[0], mf[1] == STPM_FN_SPI && !master && lvl[1],
                 mf[0] == STPM_FN_TIMER ? lvl[0] : mf[3] == STPM_FN_TIMER && lvl[3],
                 mf[1] == STPM_FN_TIMER ? lvl[1] : mf[4] == STPM_FN_TIMER && lvl[4]};
        n.fn = {mf[0], mf[1], mf[2], mf[3], mf[4]};
        n.oe_n = ~drv;
        n.out = lv;
        n.gin = lvl;
        poe_n = ~drv;
        pout = lv;
        q.push_back(n);
    endtask

    // watcher: oldest note against what the edge produced
    always @(posedge i_core_clk)
    begin : watch
        stpm_note_t n;
        #1;
        if (q.size() > 0)
        begin
            n = q.pop_front();
            check("oe_n", oe_n, n.oe_n);
            check("pull_up", pu, n.oe_n);
            check("out", out | n.oe_n, n.out | n.oe_n);
            check("func", {of[0], of[1], of[2], of[3], of[4]}, n.fn);
            check("gpio_in", gin, n.gin);
            check("engine in", {mi, mo, t2i, t3i}, n.der);
        end
    end

    initial
    begin
        seed = 32'h100f_2168;
        repeat (5) @(negedge i_core_clk);
        enter_reset();
        for (int c = 0; c < 400; c++)
        begin
            @(negedge i_core_clk);
            if (c == 200)
            begin
                enter_reset();
                repeat (2) @(negedge i_core_clk);
            end
            i_resetn = 1;
            step(c % 16 == 0 || c == 17); // back-to-back loads at 16 and 17
        end
        @(negedge i_core_clk);
        report_and_stop();
    end

    // watchdog well past the 408 cycles the run needs
    initial
    begin
        #50_000;
        mismatches++;
        report_and_stop();
    end
endmodule // stpm_pin_mux_test
